// ### gcr_pkg.sv
// constants and types for the global configuration register group
// assumes an 8-bit index/data configuration port on the host side
package gcr_pkg;

    localparam int        IDX_W          = 8;
    localparam int        NUM_LD         = 16;

    // register indices
    localparam logic [7:0] IDX_CFG_CTRL   = 8'h02;
    localparam logic [7:0] IDX_LD_SEL     = 8'h07;
    localparam logic [7:0] IDX_DEV_ID     = 8'h20;
    localparam logic [7:0] IDX_DEV_REV    = 8'h21;
    localparam logic [7:0] IDX_PWR        = 8'h22;
    localparam logic [7:0] IDX_IPM        = 8'h23;
    localparam logic [7:0] IDX_OSC        = 8'h24;
    localparam logic [7:0] IDX_ACTIVATE   = 8'h30;

    // values after reset
    localparam logic [7:0] RST_LD_SEL     = 8'h00;
    localparam logic [7:0] RST_PWR        = 8'h00;
    localparam logic [7:0] RST_IPM        = 8'h00;
    localparam logic [7:0] RST_OSC        = 8'h44;
    localparam logic [7:0] RST_INDEX      = 8'h00;

    // implemented bits; everything else reads zero
    localparam logic [7:0] PWR_MASK       = 8'h7d;
    localparam logic [7:0] IPM_MASK       = 8'h79;
    localparam logic [7:0] OSC_MASK       = 8'h4e;

    // field positions
    localparam int        CFG_SOFT_BIT   = 0;
    localparam int        ACT_BIT        = 0;
    localparam int        OSC_PLL_BIT    = 1;
    localparam int        OSC_SEL_LSB    = 2;
    localparam int        OSC_DEC_BIT    = 6;
    localparam logic [1:0] OSC_SEL_STOP   = 2'h3;

    // host port select
    localparam logic      PORT_INDEX     = 1'b0;
    localparam logic      PORT_DATA      = 1'b1;

    typedef enum logic [1:0] {
        GCR_SR_IDLE  = 2'b01,
        GCR_SR_APPLY = 2'b10
    } gcr_sr_state_t;

endpackage

// ### gcr_cfg_if.sv
// carries decoded configuration accesses from the port front end
// assumes both ends run on the same clock
`timescale 1ns/1ps
interface gcr_cfg_if;
    logic [7:0] idx;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
    logic       rd_idx;

    modport src (output idx, output wdata, output wr, output rd, output rd_idx);
    modport dst (input idx, input wdata, input wr, input rd, input rd_idx);
endinterface

// ### gcr_port_front.sv
// index/data port front end: holds the index, issues one-cycle strobes
// assumes host strobes are synchronous single-cycle pulses
`timescale 1ns/1ps
module gcr_port_front (
    // clock and reset
    input  wire logic        sys_clk_i,
    input  wire logic        rst_n_i,
    input  wire logic        ce_i,
    // host port
    input  wire logic        cfg_mode_i,
    input  wire logic        io_wr_i,
    input  wire logic        io_rd_i,
    input  wire logic        io_sel_i,
    input  wire logic [7:0]  io_wdata_i,
    // decoded access
    gcr_cfg_if.src           acc
);
    import gcr_pkg::*;

    logic [7:0] index_r;
    logic [7:0] index_nxt;
    logic [7:0] wdata_r;
    logic [7:0] wdata_nxt;
    logic       wr_r;
    logic       wr_nxt;
    logic       rd_r;
    logic       rd_nxt;
    logic       rdi_r;
    logic       rdi_nxt;

    // accesses outside configuration mode are dropped here
    always_comb begin
        index_nxt = index_r;
        wdata_nxt = wdata_r;
        wr_nxt    = 1'b0;
        rd_nxt    = 1'b0;
        rdi_nxt   = 1'b0;
        if (cfg_mode_i) begin
            if (io_wr_i && io_sel_i == PORT_INDEX) begin
                index_nxt = io_wdata_i;
            end
            if (io_wr_i && io_sel_i == PORT_DATA) begin
                wdata_nxt = io_wdata_i;
                wr_nxt    = 1'b1;
            end
            if (io_rd_i && !io_wr_i) begin
                rd_nxt  = io_sel_i == PORT_DATA;
                rdi_nxt = io_sel_i == PORT_INDEX;
            end
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            index_r <= RST_INDEX;
            wdata_r <= 8'h00;
            wr_r    <= 1'b0;
            rd_r    <= 1'b0;
            rdi_r   <= 1'b0;
        end else if (ce_i) begin
            index_r <= index_nxt;
            wdata_r <= wdata_nxt;
            wr_r    <= wr_nxt;
            rd_r    <= rd_nxt;
            rdi_r   <= rdi_nxt;
        end
    end

    assign acc.idx    = index_r;
    assign acc.wdata  = wdata_r;
    assign acc.wr     = wr_r;
    assign acc.rd     = rd_r;
    assign acc.rd_idx = rdi_r;

endmodule

// ### gcr_global_regs.sv
// global configuration register group behind an index/data port
// assumes one clock; per-device registers live outside, reached via ld_*
`timescale 1ns/1ps
module gcr_global_regs #(
    parameter logic [7:0] DEVICE_IDENTIFICATION_VALUE  = 8'ha5, // arbitrary value
    parameter logic [7:0] DEVICE_REV_VALUE = 8'h01  // arbitrary value
) (
    // clock, enable and resets
    input  wire logic                    sys_clk_i,
    input  wire logic                    rst_n_i,
    input  wire logic                    ce_i,
    input  wire logic                    standby_por_i,
    input  wire logic                    hard_reset_i,
    // host configuration port
    input  wire logic                    cfg_mode_i,
    input  wire logic                    io_wr_i,
    input  wire logic                    io_rd_i,
    input  wire logic                    io_sel_i,
    input  wire logic [7:0]              io_wdata_i,
    output logic      [7:0]              io_rdata_o,
    output logic                         io_rvalid_o,
    // per-device register access
    output logic      [7:0]              ld_select_o,
    output logic      [7:0]              ld_index_o,
    output logic      [7:0]              ld_wdata_o,
    output logic                         ld_wr_o,
    output logic                         ld_rd_o,
    input  wire logic [7:0]              ld_rdata_i,
    output logic      [gcr_pkg::NUM_LD-1:0] ld_active_o,
    // function controls
    output logic                         soft_reset_o,
    output logic      [7:0]              func_power_o,
    output logic      [7:0]              ipm_enable_o,
    output logic                         pll_off_o,
    output logic                         osc_stop_o,
    output logic                         baud_rate_generator_clk_en_o,
    output logic                         addr_qual_16_o
);
    import gcr_pkg::*;

    gcr_cfg_if acc ();

    gcr_port_front u_front (
        .sys_clk_i  (sys_clk_i),
        .rst_n_i    (rst_n_i),
        .ce_i       (ce_i),
        .cfg_mode_i (cfg_mode_i),
        .io_wr_i    (io_wr_i),
        .io_rd_i    (io_rd_i),
        .io_sel_i   (io_sel_i),
        .io_wdata_i (io_wdata_i),
        .acc        (acc)
    );

    // reset sources other than the synchronous main one
    logic          hw_rst;
    logic          soft_rst;

    // register state
    gcr_sr_state_t sr_state_r;
    gcr_sr_state_t sr_state_nxt;
    logic [7:0]    ld_sel_r;
    logic [7:0]    ld_sel_nxt;
    logic [7:0]    pwr_r;
    logic [7:0]    pwr_nxt;
    logic [7:0]    ipm_r;
    logic [7:0]    ipm_nxt;
    logic [7:0]    osc_r;
    logic [7:0]    osc_nxt;
    logic [NUM_LD-1:0] act_r;
    logic [NUM_LD-1:0] act_nxt;
    logic          osc_stop_r;

    // output flops, so no port has a gate behind it
    logic          baud_en_r;
    logic          soft_pulse_r;

    // access decode
    logic          wr_ctrl;
    logic          wr_sel;
    logic          wr_pwr;
    logic          wr_ipm;
    logic          wr_osc;
    logic          wr_act;
    logic          is_dev_idx;
    logic          sel_valid;

    // read pipeline and forwarding
    logic [7:0]    rd_local;
    logic          rd_fwd;
    logic [7:0]    rd_local_r;
    logic          rd_fwd_r;
    logic          rd_s1_r;
    logic [7:0]    rdata_r;
    logic [7:0]    rdata_nxt;
    logic          rvalid_r;
    logic          ld_wr_r;
    logic          ld_wr_nxt;
    logic [7:0]    ld_idx_r;
    logic [7:0]    ld_wd_r;

    // hard and standby resets leave the host index untouched
    assign hw_rst   = standby_por_i || hard_reset_i;
    assign soft_rst = sr_state_r == GCR_SR_APPLY;

    // exact 8-bit compares; anything unmatched up to 0x30 falls to nothing, higher indices go to the devices
    assign wr_ctrl    = acc.wr && acc.idx == IDX_CFG_CTRL;
    assign wr_sel     = acc.wr && acc.idx == IDX_LD_SEL;
    assign wr_pwr     = acc.wr && acc.idx == IDX_PWR;
    assign wr_ipm     = acc.wr && acc.idx == IDX_IPM;
    assign wr_osc     = acc.wr && acc.idx == IDX_OSC;
    // an activate write with the selector out of range is dropped
    assign sel_valid  = ld_sel_r < 8'(NUM_LD);
    assign wr_act     = acc.wr && acc.idx == IDX_ACTIVATE && sel_valid;
    assign is_dev_idx = acc.idx > IDX_ACTIVATE;

    // soft reset sequencer: one apply cycle, then back to idle
    // a soft reset written during the apply cycle is dropped: it only repeats the defaults
    always_comb begin
        case (sr_state_r)
            GCR_SR_IDLE: begin
                if (wr_ctrl && acc.wdata[CFG_SOFT_BIT]) begin
                    sr_state_nxt = GCR_SR_APPLY;
                end else begin
                    sr_state_nxt = GCR_SR_IDLE;
                end
            end
            GCR_SR_APPLY: begin
                sr_state_nxt = GCR_SR_IDLE;
            end
            // one-hot codes; an illegal code falls back to idle
            default: begin
                sr_state_nxt = GCR_SR_IDLE;
            end
        endcase
        if (hw_rst) begin
            sr_state_nxt = GCR_SR_IDLE;
        end
    end

    // global registers; a soft reset only reaches those with a soft default
    always_comb begin
        ld_sel_nxt = ld_sel_r;
        pwr_nxt    = pwr_r;
        ipm_nxt    = ipm_r;
        osc_nxt    = osc_r;
        if (hw_rst || soft_rst) begin
            ld_sel_nxt = RST_LD_SEL;
            pwr_nxt    = RST_PWR;
        end else begin
            if (wr_sel) begin
                ld_sel_nxt = acc.wdata;
            end
            if (wr_pwr) begin
                pwr_nxt = acc.wdata & PWR_MASK;
            end
        end
        if (hw_rst) begin
            ipm_nxt = RST_IPM;
            osc_nxt = RST_OSC;
        end else begin
            if (wr_ipm) begin
                ipm_nxt = acc.wdata & IPM_MASK;
            end
            // bits 5:4 are never stored, whatever software writes
            if (wr_osc) begin
                osc_nxt = acc.wdata & OSC_MASK;
            end
        end
    end

    // one activate bit per logical device
    // selector values of 16 and up record but own no activate bit
    genvar g;
    generate
        for (g = 0; g < NUM_LD; g++) begin : g_act
            always_comb begin
                if (hw_rst || soft_rst) begin
                    act_nxt[g] = 1'b0;
                end else if (wr_act && ld_sel_r == 8'(g)) begin
                    act_nxt[g] = acc.wdata[ACT_BIT];
                end else begin
                    act_nxt[g] = act_r[g];
                end
            end
        end
    endgenerate

    // read data; the control register is write-only and reads zero
    always_comb begin
        rd_fwd   = 1'b0;
        rd_local = 8'h00;
        case (acc.idx)
            IDX_LD_SEL:  rd_local = ld_sel_r;
            IDX_DEV_ID:  rd_local = DEVICE_IDENTIFICATION_VALUE;
            IDX_DEV_REV: rd_local = DEVICE_REV_VALUE;
            IDX_PWR:     rd_local = pwr_r & PWR_MASK;
            IDX_IPM:     rd_local = ipm_r & IPM_MASK;
            IDX_OSC:     rd_local = osc_r & OSC_MASK;
            IDX_ACTIVATE: begin
                if (sel_valid) begin
                    rd_local = {7'h00, act_r[ld_sel_r[3:0]]};
                end
            end
            default: begin
                rd_fwd = is_dev_idx;
            end
        endcase
        if (acc.rd_idx) begin
            rd_local = acc.idx;
            rd_fwd   = 1'b0;
        end
    end

    // second read stage: forwarded reads take the device's answer
    // ld_rdata_i is taken only in the cycle ld_rd_o stands
    always_comb begin
        rdata_nxt = rdata_r;
        if (rd_s1_r) begin
            rdata_nxt = rd_fwd_r ? ld_rdata_i : rd_local_r;
        end
    end

    assign ld_wr_nxt = acc.wr && is_dev_idx;

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            sr_state_r <= GCR_SR_IDLE;
            ld_sel_r   <= RST_LD_SEL;
            pwr_r      <= RST_PWR;
            ipm_r      <= RST_IPM;
            osc_r      <= RST_OSC;
            osc_stop_r <= 1'b0;
            baud_en_r  <= 1'b1;
            soft_pulse_r <= 1'b0;
            act_r      <= '0;
            rd_local_r <= 8'h00;
            rd_fwd_r   <= 1'b0;
            rd_s1_r    <= 1'b0;
            rdata_r    <= 8'h00;
            rvalid_r   <= 1'b0;
            ld_wr_r    <= 1'b0;
            ld_idx_r   <= 8'h00;
            ld_wd_r    <= 8'h00;
        end else if (ce_i) begin
            sr_state_r <= sr_state_nxt;
            ld_sel_r   <= ld_sel_nxt;
            pwr_r      <= pwr_nxt;
            ipm_r      <= ipm_nxt;
            osc_r      <= osc_nxt;
            osc_stop_r <= osc_nxt[OSC_SEL_LSB+:2] == OSC_SEL_STOP;
            baud_en_r  <= osc_nxt[OSC_SEL_LSB+:2] != OSC_SEL_STOP;
            soft_pulse_r <= sr_state_nxt == GCR_SR_APPLY;
            act_r      <= act_nxt;
            rd_local_r <= rd_local;
            rd_fwd_r   <= acc.rd && rd_fwd;
            rd_s1_r    <= acc.rd || acc.rd_idx;
            rdata_r    <= rdata_nxt;
            rvalid_r   <= rd_s1_r;
            ld_wr_r    <= ld_wr_nxt;
            ld_idx_r   <= acc.idx;
            ld_wd_r    <= acc.wdata;
        end
    end

    assign io_rdata_o   = rdata_r;
    assign io_rvalid_o  = rvalid_r;
    assign ld_select_o  = ld_sel_r;
    assign ld_index_o   = ld_idx_r;
    assign ld_wdata_o   = ld_wd_r;
    assign ld_wr_o      = ld_wr_r;
    assign ld_rd_o      = rd_fwd_r;
    assign ld_active_o  = act_r;
    assign soft_reset_o = soft_pulse_r;
    assign func_power_o = pwr_r;
    assign ipm_enable_o = ipm_r;
    assign pll_off_o    = osc_r[OSC_PLL_BIT];
    assign osc_stop_o   = osc_stop_r;
    // baud clock is enabled for every select code except the stop code
    assign baud_rate_generator_clk_en_o = baud_en_r;
    assign addr_qual_16_o = osc_r[OSC_DEC_BIT];

endmodule

// ### gcr_global_regs_properties.sv
// port assertions for the global configuration register group
// assumes ce_i stays high while the checked sequences run
`timescale 1ns/1ps
module gcr_global_regs_properties
    import gcr_pkg::*;
#(
    parameter logic [7:0] DEVICE_IDENTIFICATION_VALUE  = 8'ha5,
    parameter logic [7:0] DEVICE_REV_VALUE = 8'h01
) (
    // clock, enable and resets
    input wire logic                       sys_clk_i,
    input wire logic                       rst_n_i,
    input wire logic                       ce_i,
    input wire logic                       standby_por_i,
    input wire logic                       hard_reset_i,
    // host port
    input wire logic                       cfg_mode_i,
    input wire logic                       io_wr_i,
    input wire logic                       io_rd_i,
    input wire logic                       io_sel_i,
    input wire logic [7:0]                 io_wdata_i,
    input wire logic [7:0]                 io_rdata_o,
    input wire logic                       io_rvalid_o,
    // outputs under watch
    input wire logic [7:0]                 ld_select_o,
    input wire logic [7:0]                 ld_wdata_o,
    input wire logic                       ld_wr_o,
    input wire logic [gcr_pkg::NUM_LD-1:0] ld_active_o,
    input wire logic                       soft_reset_o,
    input wire logic [7:0]                 func_power_o,
    input wire logic                       pll_off_o,
    input wire logic                       osc_stop_o,
    input wire logic                       baud_rate_generator_clk_en_o,
    input wire logic                       addr_qual_16_o
);
    logic       rd_req;
    logic       wr_req;
    logic [7:0] idx_r;
    logic [7:0] idx_nxt;

    assign rd_req = cfg_mode_i && ce_i && io_rd_i && !io_wr_i;
    assign wr_req = cfg_mode_i && ce_i && io_wr_i;

    // shadow of the index so data accesses can be tied to their register
    always_comb begin
        idx_nxt = idx_r;
        if (wr_req && !io_sel_i) begin
            idx_nxt = io_wdata_i;
        end
    end
    always_ff @(posedge sys_clk_i) begin
        idx_r <= rst_n_i ? idx_nxt : 8'h00;
    end

    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!rst_n_i);

    sequence s_data_rd(logic [7:0] i);
        rd_req && io_sel_i && idx_r == i;
    endsequence
    sequence s_ld_wr;
        wr_req && io_sel_i && idx_r > 8'h30;
    endsequence

    a_read_answer_lat: assert property (rd_req |-> ##3 io_rvalid_o)
        else $error("read answer late");
    a_rvalid_needs_read: assert property (io_rvalid_o |-> $past(rd_req, 3))
        else $error("read answer without read");
    a_id_read_const: assert property (s_data_rd(IDX_DEV_ID) |-> ##3 io_rdata_o == DEVICE_IDENTIFICATION_VALUE)
        else $error("identification value wrong");
    a_rev_read_const: assert property (s_data_rd(IDX_DEV_REV) |-> ##3 io_rdata_o == DEVICE_REV_VALUE)
        else $error("revision value wrong");
    a_reserved_reads_zero: assert property (rd_req && io_sel_i && (idx_r < 8'h02
        || idx_r inside {[8'h08:8'h1f]}) |-> ##3 io_rdata_o == 8'h00)
        else $error("reserved index read nonzero");
    a_soft_pulse_once: assert property (soft_reset_o |=> !soft_reset_o)
        else $error("soft reset not self clearing");
    a_soft_clears_state: assert property (soft_reset_o |=> func_power_o == 8'h00
        && ld_select_o == 8'h00 && ld_active_o == '0)
        else $error("soft reset left state");
    a_ld_write_fwd: assert property (s_ld_wr |-> ##2 ld_wr_o && ld_wdata_o == $past(io_wdata_i, 2))
        else $error("per-device write not forwarded");
    a_hard_defaults: assert property ((hard_reset_i || standby_por_i) && ce_i |=> !pll_off_o
        && !osc_stop_o && addr_qual_16_o && func_power_o == 8'h00)
        else $error("defaults not loaded");
    a_baud_follows_osc: assert property (baud_rate_generator_clk_en_o != osc_stop_o)
        else $error("baud clock enable disagrees");
    a_power_reserved_zero: assert property ((func_power_o & ~PWR_MASK) == 8'h00)
        else $error("reserved power bit set");
endmodule

bind gcr_global_regs gcr_global_regs_properties #(
    .DEVICE_IDENTIFICATION_VALUE (DEVICE_IDENTIFICATION_VALUE),
    .DEVICE_REV_VALUE(DEVICE_REV_VALUE)
) u_props (.sys_clk_i, .rst_n_i, .ce_i, .standby_por_i, .hard_reset_i, .cfg_mode_i, .io_wr_i,
    .io_rd_i, .io_sel_i, .io_wdata_i, .io_rdata_o, .io_rvalid_o, .ld_select_o, .ld_wdata_o,
    .ld_wr_o, .ld_active_o, .soft_reset_o, .func_power_o, .pll_off_o, .osc_stop_o,
    .baud_rate_generator_clk_en_o, .addr_qual_16_o);

// ### gcr_host_model.sv
// host bridge model: index/data port cycles plus per-device answers
// assumes the block samples strobes on the rising edge
`timescale 1ns/1ps
module gcr_host_model (
    // clock
    input  wire logic       sys_clk_i,
    // host port
    output logic            wr_o,
    output logic            rd_o,
    output logic            sel_o,
    output logic [7:0]      wdata_o,
    input  wire logic [7:0] rdata_i,
    input  wire logic       rvalid_i,
    // per-device registers
    input  wire logic [7:0] ld_index_i,
    input  wire logic       ld_rd_i,
    output logic [7:0]      ld_rdata_o
);
    // answer depends on the index so a wrong steer shows up; off-strobe it shows the inverse
    assign ld_rdata_o = ld_rd_i ? ld_index_i ^ 8'h3c : ~(ld_index_i ^ 8'h3c);
    initial {wr_o, rd_o, sel_o, wdata_o} = 11'h000;

    task automatic cyc(input logic s, input logic w, input logic [7:0] d, output logic [7:0] q);
        @(posedge sys_clk_i);
        wr_o <= w;
        rd_o <= !w;
        sel_o <= s;
        wdata_o <= d;
        @(posedge sys_clk_i);
        wr_o <= 1'b0;
        rd_o <= 1'b0;
        // released bus shows the inverse, never the stale value
        wdata_o <= ~d;
        q = 8'hxx;
        for (int i = 0; i < 6 && !w; i++) begin
            @(negedge sys_clk_i);
            if (rvalid_i === 1'b1) begin
                q = rdata_i;
            end
        end
    endtask
endmodule

// ### gcr_global_regs_test.sv
// self-checking bench for the global configuration register group
// assumes the host model drives the port and answers per-device reads
`timescale 1ns/1ps
module gcr_global_regs_test;
    import gcr_pkg::*;
    localparam logic [7:0] TB_ID  = 8'h3a; // arbitrary value
    localparam logic [7:0] TB_REV = 8'h07; // arbitrary value
    logic              sys_clk_i = 1'b0;
    logic              rst_n_i = 1'b0;
    logic              ce_i = 1'b1;
    logic              standby_por_i = 1'b0;
    logic              hard_reset_i = 1'b0;
    logic              cfg_mode_i = 1'b1;
    logic              io_wr_i, io_rd_i, io_sel_i, io_rvalid_o, soft_reset_o;
    logic              pll_off_o, osc_stop_o, baud_rate_generator_clk_en_o, addr_qual_16_o;
    logic [7:0]        io_wdata_i, io_rdata_o, ld_select_o, ld_index_o, ld_rdata_i;
    logic [7:0]        func_power_o, ipm_enable_o, ld_wdata_o;
    logic [7:0]        fwd_idx = 8'h00;
    logic [7:0]        fwd_data = 8'h00;
    logic              ld_wr_o, ld_rd_o;
    logic [NUM_LD-1:0] ld_active_o;
    int                n_errors = 0;
    int                check_count = 0;
    int                cycles = 0;

    always #10 sys_clk_i = ~sys_clk_i;

    gcr_global_regs #(.DEVICE_IDENTIFICATION_VALUE(TB_ID), .DEVICE_REV_VALUE(TB_REV)) u_dut (.sys_clk_i,
        .rst_n_i, .ce_i, .standby_por_i, .hard_reset_i, .cfg_mode_i, .io_wr_i, .io_rd_i,
        .io_sel_i, .io_wdata_i, .io_rdata_o, .io_rvalid_o, .ld_select_o, .ld_index_o,
        .ld_wdata_o, .ld_wr_o, .ld_rd_o, .ld_rdata_i, .ld_active_o, .soft_reset_o,
        .func_power_o, .ipm_enable_o, .pll_off_o, .osc_stop_o, .baud_rate_generator_clk_en_o,
        .addr_qual_16_o);
    gcr_host_model u_host (.sys_clk_i, .wr_o(io_wr_i), .rd_o(io_rd_i), .sel_o(io_sel_i),
        .wdata_o(io_wdata_i), .rdata_i(io_rdata_o), .rvalid_i(io_rvalid_o),
        .ld_index_i(ld_index_o), .ld_rd_i(ld_rd_o), .ld_rdata_o(ld_rdata_i));

    // last forwarded write, taken while its strobe stands
    always @(posedge sys_clk_i) begin
        if (ld_wr_o === 1'b1) begin
            fwd_idx <= ld_index_o;
            fwd_data <= ld_wdata_o;
        end
    end

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr_reg(input logic [7:0] i, input logic [7:0] d);
        logic [7:0] q;
        u_host.cyc(PORT_INDEX, 1'b1, i, q);
        u_host.cyc(PORT_DATA, 1'b1, d, q);
        // soft reset lands one cycle after ordinary writes
        repeat (4) @(negedge sys_clk_i);
    endtask
    task automatic chk_reg(input string what, input logic [7:0] i, input logic [7:0] exp);
        logic [7:0] q;
        u_host.cyc(PORT_INDEX, 1'b1, i, q);
        u_host.cyc(PORT_DATA, 1'b0, 8'h00, q);
        chk(what, {8'h00, exp}, {8'h00, q});
    endtask
    function automatic logic [15:0] osc_pins();
        return {12'h000, pll_off_o, osc_stop_o, baud_rate_generator_clk_en_o, addr_qual_16_o};
    endfunction

    task automatic t_defaults();
        logic [7:0] q;
        chk_reg("ctrl", IDX_CFG_CTRL, 8'h00);
        chk_reg("sel", IDX_LD_SEL, 8'h00);
        chk_reg("ipm", IDX_IPM, 8'h00);
        chk_reg("osc", IDX_OSC, 8'h44);
        wr_reg(IDX_DEV_ID, ~TB_ID);
        wr_reg(IDX_DEV_REV, ~TB_REV);
        chk_reg("id", IDX_DEV_ID, TB_ID);
        chk_reg("rev", IDX_DEV_REV, TB_REV);
        u_host.cyc(PORT_INDEX, 1'b0, 8'h00, q);
        chk("index read", 16'h0021, {8'h00, q});
        chk("osc pins", 16'h0003, osc_pins());
        $display("test defaults done");
    endtask
    task automatic t_reserved();
        logic [7:0] idx [8] = '{8'h00, 8'h01, 8'h03, 8'h06, 8'h08, 8'h1f, 8'h25, 8'h2f};
        foreach (idx[k]) begin
            wr_reg(idx[k], 8'hff);
            chk_reg("reserved", idx[k], 8'h00);
        end
        chk_reg("pwr", IDX_PWR, 8'h00);
        $display("test reserved done");
    endtask
    task automatic t_fields();
        wr_reg(IDX_PWR, 8'hff);
        chk("pwr pins", 16'h007d, {8'h00, func_power_o});
        chk_reg("pwr", IDX_PWR, 8'h7d);
        wr_reg(IDX_IPM, 8'hff);
        chk("ipm pins", 16'h0079, {8'h00, ipm_enable_o});
        chk_reg("ipm", IDX_IPM, 8'h79);
        for (int c = 0; c < 4; c++) begin
            wr_reg(IDX_OSC, 8'h02 | 8'(c << 2));
            chk("osc pins", {12'h000, 1'b1, c == 3, c != 3, 1'b0}, osc_pins());
        end
        $display("test fields done");
    endtask
    task automatic t_select();
        wr_reg(IDX_LD_SEL, 8'h03);
        wr_reg(IDX_ACTIVATE, 8'h01);
        wr_reg(IDX_LD_SEL, 8'h05);
        wr_reg(IDX_ACTIVATE, 8'h01);
        wr_reg(IDX_LD_SEL, 8'h03);
        wr_reg(IDX_ACTIVATE, 8'h00);
        chk("active", 16'h0020, ld_active_o);
        chk("select", 16'h0003, {8'h00, ld_select_o});
        wr_reg(IDX_LD_SEL, 8'h05);
        chk_reg("act", IDX_ACTIVATE, 8'h01);
        wr_reg(8'h60, 8'hab);
        chk("fwd write", 16'h60ab, {fwd_idx, fwd_data});
        chk_reg("ld read", 8'hf0, 8'hf0 ^ 8'h3c);
        $display("test select done");
    endtask
    task automatic t_soft();
        wr_reg(IDX_PWR, 8'h11);
        wr_reg(IDX_IPM, 8'h09);
        wr_reg(IDX_CFG_CTRL, 8'h01);
        chk("pwr pins", 16'h0000, {8'h00, func_power_o});
        chk("active", 16'h0000, ld_active_o);
        chk_reg("sel", IDX_LD_SEL, 8'h00);
        chk_reg("ctrl", IDX_CFG_CTRL, 8'h00);
        chk_reg("ipm", IDX_IPM, 8'h09);
        chk_reg("osc", IDX_OSC, 8'h0e);
        chk("soft pulse", 16'h0000, {15'h0000, soft_reset_o});
        wr_reg(IDX_PWR, 8'h11);
        chk("pwr kept", 16'h0011, {8'h00, func_power_o});
        $display("test soft reset done");
    endtask
    task automatic t_hard();
        for (int k = 0; k < 2; k++) begin
            wr_reg(IDX_OSC, 8'h0e);
            wr_reg(IDX_PWR, 8'h7d);
            @(posedge sys_clk_i);
            hard_reset_i <= (k == 0);
            standby_por_i <= (k == 1);
            @(posedge sys_clk_i);
            hard_reset_i <= 1'b0;
            standby_por_i <= 1'b0;
            @(negedge sys_clk_i);
            chk("osc pins", 16'h0003, osc_pins());
            chk("pwr pins", 16'h0000, {8'h00, func_power_o});
        end
        @(posedge sys_clk_i);
        cfg_mode_i <= 1'b0;
        wr_reg(IDX_PWR, 8'h11);
        @(posedge sys_clk_i);
        cfg_mode_i <= 1'b1;
        chk_reg("pwr", IDX_PWR, 8'h00);
        @(posedge sys_clk_i);
        ce_i <= 1'b0;
        wr_reg(IDX_PWR, 8'h11);
        @(posedge sys_clk_i);
        ce_i <= 1'b1;
        chk_reg("pwr frozen", IDX_PWR, 8'h00);
        $display("test resets done");
    endtask

    task automatic complete_run();
        $display("checks %0d mismatches %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    always @(posedge sys_clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_errors++;
            complete_run();
        end
    end

    initial begin
        repeat (3) @(posedge sys_clk_i);
        rst_n_i <= 1'b1;
        t_defaults();
        t_reserved();
        t_fields();
        t_select();
        t_soft();
        t_hard();
        complete_run();
    end
endmodule
